// ---- logic/fra_fault_aggregator.sv ----
// Fault aggregator: status, masking, alert pin, header byte, AXI4-Lite
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps

module fra_fault_aggregator (
	input  wire logic                       ref_clk,
	input  wire logic                       rst_n,
	// AXI4-Lite slave
	input  wire logic [fra_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                       awvalid,
	output      logic                       awready,
	input  wire logic [31:0]                wdata,
	input  wire logic [3:0]                 wstrb,
	input  wire logic                       wvalid,
	output      logic                       wready,
	output      logic [1:0]                 bresp,
	output      logic                       bvalid,
	input  wire logic                       bready,
	input  wire logic [fra_pkg::ADDR_W-1:0] araddr,
	input  wire logic                       arvalid,
	output      logic                       arready,
	output      logic [31:0]                rdata,
	output      logic [1:0]                 rresp,
	output      logic                       rvalid,
	input  wire logic                       rready,
	// Monitor pins, asynchronous
	input  wire logic [1:0]                 heatWarnPin,
	input  wire logic [1:0]                 heatShutdownPin,
	input  wire logic [1:0]                 shortTripPin,
	input  wire logic                       batteryUvPin,
	input  wire logic                       logicLockoutPin,
	input  wire logic                       safeStateRequestPin,
	// Same clock inputs from neighbouring logic
	input  wire logic                       lowPowerState,
	input  wire logic                       watchdogTimeout,
	input  wire logic                       frameLengthError,
	input  wire logic                       frameCheckFail,
	// Alert pin, open drain
	input  wire logic                       faultAlertPinI,
	output      logic                       faultAlertPinO,
	output      logic                       faultAlertPinOe,
	// Header byte for the serial frame and interrupt
	output      logic [7:0]                 headerByte,
	output      logic                       irq
);

	////////////////////////////////////////////////////////////////////////
	// State of the whole block
	typedef struct packed {
		logic                     awHeld;  // Write address captured
		logic [7:0]               awAddr;
		logic                     wHeld;   // Write data captured
		logic [31:0]              wData;
		logic [3:0]               wStrb;
		logic                     awReady;
		logic                     wReady;
		logic                     bValid;
		logic [1:0]               bResp;
		logic                     arReady;
		logic                     rValid;
		logic [31:0]              rData;
		logic [1:0]               rResp;
		logic [15:0]              glob;    // Global summary status
		logic [1:0][2:0]          ch;      // Per channel event status
		logic [1:0]               mask;    // Pin mask
		logic [2:0]               cfg;     // Configuration
		logic [3:0]               irqSt;   // Sticky interrupt status
		logic [3:0]               irqMask; // Interrupt enables
		logic [1:0]               pend;    // Short seen in low power
		logic                     pinOe;   // Pulling the alert pin low
		logic                     pinO;    // Driven level, always low
		logic [7:0]               hdr;     // Header byte
		logic                     irq;
	} fra_state_type;

	fra_state_type q;        // Registered state
	fra_state_type d;        // Next state
	logic [9:0]    syncOut;  // Filtered pin levels
	logic          rdGlob;   // Global status read taken this cycle
	logic [1:0]    rdCh;     // Channel status read taken this cycle

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers, one bank for every asynchronous input
	fra_sync #(
		.WIDTH (10)
	) u_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.asyncIn ({faultAlertPinI, safeStateRequestPin, logicLockoutPin,
		           batteryUvPin, shortTripPin, heatShutdownPin,
		           heatWarnPin}),
		.syncOut (syncOut)
	);

	wire logic [1:0] warnS   = syncOut[1:0]; // Heat warning per channel
	wire logic [1:0] sdS     = syncOut[3:2]; // Heat shutdown per channel
	wire logic [1:0] shortS  = syncOut[5:4]; // Short trip per channel
	wire logic       battS   = syncOut[6];
	wire logic       logicS  = syncOut[7];
	wire logic       safeS   = syncOut[8];
	wire logic       pinLvlS = syncOut[9];

	////////////////////////////////////////////////////////////////////////
	// Next state: bus slave, status update, pin and interrupt
	always_comb begin
		logic [2:0] chLive;
		logic [4:0] devLive;
		logic       latchDis;
		logic       anyChRead;
		logic       tripLive;
		logic       pinCause;
		logic       rdIrq;
		logic [7:0] rAddr;
		logic [7:0] wAddr;
		chLive    = '0;
		devLive   = '0;
		latchDis  = q.cfg[fra_pkg::F_LATCHDIS];
		anyChRead = 1'b0;
		tripLive  = 1'b0;
		pinCause  = 1'b0;
		rdIrq     = 1'b0;
		rAddr     = {araddr[7:2], 2'b00};
		wAddr     = {q.awAddr[7:2], 2'b00};
		rdGlob    = 1'b0;
		rdCh      = '0;
		d         = q;

		// Write channels are taken independently and held
		if (awvalid && q.awReady) begin
			d.awHeld = 1'b1;
			d.awAddr = awaddr;
		end
		if (wvalid && q.wReady) begin
			d.wHeld = 1'b1;
			d.wData = wdata;
			d.wStrb = wstrb;
		end
		// Response retires first so a new write may start
		if (q.bValid && bready) begin
			d.bValid = 1'b0;
		end
		// Both halves held: perform the write and answer
		if (q.awHeld && q.wHeld && !q.bValid) begin
			d.awHeld = 1'b0;
			d.wHeld  = 1'b0;
			d.bValid = 1'b1;
			d.bResp  = fra_pkg::RESP_OKAY;
			if (wAddr == fra_pkg::OFF_MASK) begin
				if (q.wStrb[0]) d.mask = q.wData[1:0];
			end else if (wAddr == fra_pkg::OFF_CFG) begin
				if (q.wStrb[0]) d.cfg = q.wData[2:0];
			end else if (wAddr == fra_pkg::OFF_IRQ_MASK) begin
				if (q.wStrb[0]) d.irqMask = q.wData[3:0];
			end else if (wAddr > fra_pkg::OFF_PIN) begin
				// Status registers ignore writes, the rest is unmapped
				d.bResp = fra_pkg::RESP_SLV;
			end
		end
		d.awReady = !d.awHeld && !d.bValid;
		d.wReady  = !d.wHeld && !d.bValid;

		// Read: one outstanding, data captured at the take
		if (q.rValid && rready) begin
			d.rValid  = 1'b0;
			d.arReady = 1'b1;
		end
		if (arvalid && q.arReady) begin
			d.rValid  = 1'b1;
			d.arReady = 1'b0;
			d.rData   = '0;
			d.rResp   = fra_pkg::RESP_OKAY;
			if (rAddr == fra_pkg::OFF_GLOBAL) begin
				d.rData[15:0] = q.glob;
				rdGlob        = 1'b1;
			end else if (rAddr == fra_pkg::OFF_CH1) begin
				d.rData[2:0] = q.ch[0];
				rdCh[0]      = 1'b1;
			end else if (rAddr == fra_pkg::OFF_CH2) begin
				d.rData[2:0] = q.ch[1];
				rdCh[1]      = 1'b1;
			end else if (rAddr == fra_pkg::OFF_MASK) begin
				d.rData[1:0] = q.mask;
			end else if (rAddr == fra_pkg::OFF_CFG) begin
				d.rData[2:0] = q.cfg;
			end else if (rAddr == fra_pkg::OFF_IRQ_ST) begin
				d.rData[3:0] = q.irqSt;
				rdIrq        = 1'b1;
			end else if (rAddr == fra_pkg::OFF_IRQ_MASK) begin
				d.rData[3:0] = q.irqMask;
			end else if (rAddr == fra_pkg::OFF_PIN) begin
				d.rData[0] = pinLvlS;
			end else begin
				d.rResp = fra_pkg::RESP_SLV;
			end
		end
		// Ready again as soon as no read answer stands, so the read
		// channel opens at the first edge after reset
		d.arReady = !d.rValid;
		anyChRead = |rdCh;

		// Channel events; a live event always beats a read clear
		for (int c = 0; c < 2; c++) begin
			// Shorts wait out low power, then commit on leaving it
			d.pend[c] = lowPowerState ? (q.pend[c] | shortS[c]) : 1'b0;
			chLive[fra_pkg::C_WARN]  = warnS[c];
			chLive[fra_pkg::C_SD]    = sdS[c];
			chLive[fra_pkg::C_SHORT] = !lowPowerState &&
			                           (shortS[c] || q.pend[c]);
			d.ch[c] = chLive | (q.ch[c] & ~{3{rdCh[c]}});
			// Summary flag follows live or latches until read
			if (latchDis) begin
				d.glob[fra_pkg::G_CHFLAG+c] = |chLive;
			end else begin
				d.glob[fra_pkg::G_CHFLAG+c] = (|chLive) ||
					(q.glob[fra_pkg::G_CHFLAG+c] && !rdCh[c]);
			end
			tripLive = tripLive || chLive[fra_pkg::C_SD] ||
			           chLive[fra_pkg::C_SHORT];
			pinCause = pinCause || q.ch[c][fra_pkg::C_SD] ||
			           q.ch[c][fra_pkg::C_SHORT];
		end
		// Trip is cleared by reading either channel register
		if (latchDis) begin
			d.glob[fra_pkg::G_TRIP] = tripLive;
		end else begin
			d.glob[fra_pkg::G_TRIP] = tripLive ||
				(q.glob[fra_pkg::G_TRIP] && !anyChRead);
		end

		// Device level events
		devLive[fra_pkg::G_BATT]  = battS;
		devLive[fra_pkg::G_LOGIC] = logicS;
		devLive[fra_pkg::G_WD]    = watchdogTimeout &&
		                            q.cfg[fra_pkg::F_WDON];
		devLive[fra_pkg::G_SER]   = frameLengthError ||
			(frameCheckFail && q.cfg[fra_pkg::F_CRCON]);
		devLive[fra_pkg::G_SAFE]  = safeS;
		d.glob[4:0] = devLive | (q.glob[4:0] & ~{5{rdGlob}});
		if (latchDis) begin
			d.glob[fra_pkg::G_DEVERR] = |devLive;
		end else begin
			d.glob[fra_pkg::G_DEVERR] = (|devLive) ||
				(q.glob[fra_pkg::G_DEVERR] && !rdGlob);
		end

		// Pin: only shutdowns, unmasked watchdog and unmasked serial faults pull it low
		pinCause = pinCause ||
			(q.glob[fra_pkg::G_WD] && !q.mask[fra_pkg::M_WD]) ||
			(q.glob[fra_pkg::G_SER] && !q.mask[fra_pkg::M_SER]);
		d.pinOe = pinCause && !lowPowerState;
		d.pinO  = 1'b0;
		d.hdr   = d.glob[15:8];

		// Interrupt on rising flags; set wins over the read clear
		d.irqSt = q.irqSt & ~{4{rdIrq}};
		for (int c = 0; c < 2; c++) begin
			if (d.glob[fra_pkg::G_CHFLAG+c] && !q.glob[fra_pkg::G_CHFLAG+c])
				d.irqSt[fra_pkg::I_CH+c] = 1'b1;
		end
		if (d.glob[fra_pkg::G_DEVERR] && !q.glob[fra_pkg::G_DEVERR])
			d.irqSt[fra_pkg::I_DEV] = 1'b1;
		if (d.pinOe && !q.pinOe)
			d.irqSt[fra_pkg::I_PIN] = 1'b1;
		d.irq = |(d.irqSt & d.irqMask);
	end

	////////////////////////////////////////////////////////////////////////
	// Register the state; readies rise at the first edge after reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q         <= '0;
			q.mask    <= fra_pkg::MASK_RST;
			q.cfg     <= fra_pkg::CFG_RST;
			q.irqMask <= fra_pkg::IRQ_RST;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state
	assign awready         = q.awReady;
	assign wready          = q.wReady;
	assign bvalid          = q.bValid;
	assign bresp           = q.bResp;
	assign arready         = q.arReady;
	assign rvalid          = q.rValid;
	assign rdata           = q.rData;
	assign rresp           = q.rResp;
	assign faultAlertPinO  = q.pinO;
	assign faultAlertPinOe = q.pinOe;
	assign headerByte      = q.hdr;
	assign irq             = q.irq;

	////////////////////////////////////////////////////////////////////////
	// Checks on the behaviour above
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence lpShortSeq;
		lowPowerState && shortS[1] ##1 !lowPowerState;
	endsequence

	pin_lowpower_a: assert property (
		lowPowerState |=> !faultAlertPinOe)
		else $error("alert pin driven in low power");

	pin_cause_a: assert property (
		faultAlertPinOe |-> $past(q.ch[0][1] || q.ch[1][1] || q.ch[0][2] ||
			q.ch[1][2] || (q.glob[2] && !q.mask[0]) ||
			(q.glob[3] && !q.mask[1])))
		else $error("alert pin low without a pin cause");

	wd_pin_a: assert property (
		(q.glob[2] && !q.mask[0] && !lowPowerState) |=> faultAlertPinOe)
		else $error("watchdog flag did not pull the pin");

	heat_sd_a: assert property (
		(sdS[1] && !q.cfg[0]) |=> (q.ch[1][1] && q.glob[10] && q.glob[13]))
		else $error("heat shutdown not recorded");

	battery_uv_a: assert property (
		battS |=> (q.glob[0] && q.glob[8]))
		else $error("battery warning not recorded");

	serial_err_a: assert property (
		frameLengthError |=> (q.glob[3] && q.glob[8]))
		else $error("frame length error not recorded");

	check_fail_a: assert property (
		(frameCheckFail && q.cfg[2]) |=> q.glob[3])
		else $error("frame check failure not recorded");

	latch_hold_a: assert property (
		(q.glob[8] && !q.cfg[0] && !rdGlob) |=> q.glob[8])
		else $error("latched device flag dropped without a read");

	lp_short_a: assert property (
		lpShortSeq |=> q.ch[1][2] ##0 q.glob[10])
		else $error("short in low power not reported after leaving");

	header_copy_a: assert property (
		headerByte == q.glob[15:8])
		else $error("header byte differs from summary");

endmodule : fra_fault_aggregator

// ---- logic/fra_pkg.sv ----
// Package of offsets, field positions and reset values for the fault aggregator
package fra_pkg;

	////////////////////////////////////////////////////////////////////////
	// Bus geometry and responses
	localparam int unsigned ADDR_W    = 8;     // Byte address width
	localparam int unsigned NUM_CH    = 2;     // Switch channels served
	localparam logic [1:0]  RESP_OKAY = 2'h0;  // Normal answer
	localparam logic [1:0]  RESP_SLV  = 2'h2;  // Answer to an unmapped address

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] OFF_GLOBAL   = 8'h00; // Global summary status
	localparam logic [7:0] OFF_CH1      = 8'h04; // Channel 1 event status
	localparam logic [7:0] OFF_CH2      = 8'h08; // Channel 2 event status
	localparam logic [7:0] OFF_MASK     = 8'h0c; // Pin indication mask
	localparam logic [7:0] OFF_CFG      = 8'h10; // Device configuration
	localparam logic [7:0] OFF_IRQ_ST   = 8'h14; // Sticky interrupt status
	localparam logic [7:0] OFF_IRQ_MASK = 8'h18; // Interrupt enable mask
	localparam logic [7:0] OFF_PIN      = 8'h1c; // Alert pin level, read only

	////////////////////////////////////////////////////////////////////////
	// Global summary status fields
	localparam int unsigned G_BATT   = 0;  // Battery undervoltage warning
	localparam int unsigned G_LOGIC  = 1;  // Logic supply lockout
	localparam int unsigned G_WD     = 2;  // Watchdog timeout flag
	localparam int unsigned G_SER    = 3;  // Serial frame or check error
	localparam int unsigned G_SAFE   = 4;  // Safe state status
	localparam int unsigned G_DEVW   = 5;  // Width of the device detail field
	localparam int unsigned G_DEVERR = 8;  // Device error or warning flag
	localparam int unsigned G_TRIP   = 10; // Channel protection trip
	localparam int unsigned G_CHFLAG = 12; // Channel summary flags, one per ch

	////////////////////////////////////////////////////////////////////////
	// Per channel event status fields
	localparam int unsigned C_WARN  = 0; // Heat warning
	localparam int unsigned C_SD    = 1; // Heat shutdown
	localparam int unsigned C_SHORT = 2; // Short circuit shutdown
	localparam int unsigned CH_W    = 3; // Field width

	////////////////////////////////////////////////////////////////////////
	// Mask, configuration and interrupt fields with reset values
	localparam int unsigned M_WD       = 0;    // Mask watchdog on the pin
	localparam int unsigned M_SER      = 1;    // Mask serial error on the pin
	localparam int unsigned MASK_W     = 2;
	localparam logic [1:0]  MASK_RST   = 2'h0;
	localparam int unsigned F_LATCHDIS = 0;    // Status latch disable
	localparam int unsigned F_WDON     = 1;    // Watchdog on
	localparam int unsigned F_CRCON    = 2;    // Frame check on
	localparam int unsigned CFG_W      = 3;
	localparam logic [2:0]  CFG_RST    = 3'h0;
	localparam int unsigned I_CH       = 0;    // Channel flag rose, one per ch
	localparam int unsigned I_DEV      = 2;    // Device flag rose
	localparam int unsigned I_PIN      = 3;    // Alert pin asserted
	localparam int unsigned IRQ_W      = 4;
	localparam logic [3:0]  IRQ_RST    = 4'h0;

endpackage : fra_pkg

// ---- logic/fra_sync.sv ----
// Three stage input synchroniser with agreement filter
`timescale 1ns/10ps

module fra_sync #(
	parameter int unsigned WIDTH = 1  // Number of independent inputs
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] asyncIn,
	output      logic [WIDTH-1:0] syncOut
);

	initial begin
		if (WIDTH < 1) begin
			$error("fra_sync needs at least one input");
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State: three stages and the accepted value
	typedef struct packed {
		logic [WIDTH-1:0] s1;  // Metastable stage, read by s2 only
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] val; // Accepted level
	} fra_sync_type;

	fra_sync_type q;  // Registered state
	fra_sync_type d;  // Next state

	// Shift, accept a change only when stages two and three agree
	always_comb begin
		d    = q;
		d.s1 = asyncIn;
		d.s2 = q.s1;
		d.s3 = q.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				d.val[i] = q.s3[i];
			end
		end
	end

	// Register the whole state
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign syncOut = q.val;

endmodule : fra_sync

// ---- sim/fra_host_pin.sv ----
// Host side of the open drain alert wire, with its pull-up
`timescale 1ns/10ps

module fra_host_pin (
	input  wire logic faultAlertPinO,  // Device drive value, low only
	input  wire logic faultAlertPinOe, // Device is pulling the wire
	output      logic wireLevel        // Level seen by host and device
);

	////////////////////////////////////////////////////////////////////////
	// Pull-up wins while released, so a stale low can never linger
	assign wireLevel = faultAlertPinOe ? faultAlertPinO : 1'b1;

endmodule : fra_host_pin

// ---- sim/test_fra_fault_aggregator.sv ----
// Self-checking bench for the fault aggregator over its register bus
`timescale 1ns/10ps

module test_fra_fault_aggregator;

	logic        ref_clk, rst_n;         // Clock and reset
	logic [7:0]  awaddr, araddr;         // Bus addresses
	logic        awvalid, wvalid, bready; // Write side handshakes
	logic        arvalid, rready;        // Read side handshakes
	logic [31:0] wdata, rdata;           // Bus data
	logic [3:0]  wstrb;                  // Byte strobes, all on
	logic        awready, wready, bvalid; // Write answers
	logic        arready, rvalid;        // Read answers
	logic [1:0]  bresp, rresp;           // Response codes
	logic [11:0] cause;                  // Event inputs, mapped below
	logic        lowPower;               // Low power state
	logic        pinO, pinOe, pinLevel;  // Alert wire
	logic        irq;                    // Interrupt level
	logic [7:0]  headerByte;             // Frame header byte
	int          fails, checked;         // Verdict counters
	int          cycles = 0;             // Hang guard

	////////////////////////////////////////////////////////////////////////
	// Design and host pin model
	fra_fault_aggregator u_fra_fault_aggregator (
		.ref_clk(ref_clk), .rst_n(rst_n), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready),
		.heatWarnPin(cause[1:0]), .heatShutdownPin(cause[3:2]),
		.shortTripPin(cause[5:4]), .batteryUvPin(cause[6]),
		.logicLockoutPin(cause[7]), .safeStateRequestPin(cause[8]),
		.lowPowerState(lowPower), .watchdogTimeout(cause[9]),
		.frameLengthError(cause[10]), .frameCheckFail(cause[11]),
		.faultAlertPinI(pinLevel), .faultAlertPinO(pinO),
		.faultAlertPinOe(pinOe), .headerByte(headerByte), .irq(irq));

	fra_host_pin u_fra_host_pin (
		.faultAlertPinO(pinO), .faultAlertPinOe(pinOe),
		.wireLevel(pinLevel));

	////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// A hang counts as a mismatch and still reaches the verdict
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			test_done();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Comparison and verdict
	task automatic check(input string what, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic test_done();
		$display("checked %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done

	////////////////////////////////////////////////////////////////////////
	// Bus cycles: hold each channel until its own ready edge
	task automatic busWrite(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge ref_clk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		check("bresp", {30'h0, bresp}, {30'h0, er});
	endtask : busWrite

	task automatic busRead(input logic [7:0] a, input logic [31:0] exp,
		input logic [1:0] er);
		@(posedge ref_clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		check("rdata", rdata, exp);
		check("rresp", {30'h0, rresp}, {30'h0, er});
	endtask : busRead

	////////////////////////////////////////////////////////////////////////
	// Fault scenarios
	// Latched bits outlive the cause; channel read, then global read clear
	task automatic clearAll(input logic [31:0] glob, input logic [7:0] ch,
		input logic [31:0] chExp);
		busRead(ch, chExp, fra_pkg::RESP_OKAY);
		busRead(fra_pkg::OFF_GLOBAL, glob & ~32'h3400, 2'h0);
		busRead(fra_pkg::OFF_GLOBAL, 32'h0, fra_pkg::RESP_OKAY);
		busRead(ch, 32'h0, fra_pkg::RESP_OKAY);
		repeat (2) @(posedge ref_clk);
		check("pinOe", {31'h0, pinOe}, 32'h0);
	endtask : clearAll

	// One cause raised under a config, flags and pin checked, then cleared
	task automatic oneEvent(input int n, input logic [2:0] cfg,
		input logic [31:0] glob, input logic [7:0] ch,
		input logic [31:0] chExp, input logic pin);
		busWrite(fra_pkg::OFF_CFG, {29'h0, cfg}, fra_pkg::RESP_OKAY);
		cause[n] <= 1'b1;
		// Long enough for the wire level to cross its synchroniser too
		repeat (12) @(posedge ref_clk);
		check("pinOe", {31'h0, pinOe}, {31'h0, pin});
		check("header", {24'h0, headerByte}, {24'h0, glob[15:8]});
		check("irq", {31'h0, irq}, 32'h0);
		busRead(fra_pkg::OFF_PIN, {31'h0, ~pin}, 2'h0);
		busRead(fra_pkg::OFF_GLOBAL, glob, fra_pkg::RESP_OKAY);
		cause[n] <= 1'b0;
		repeat (8) @(posedge ref_clk);
		check("pinOe held", {31'h0, pinOe}, {31'h0, pin});
		clearAll(glob, ch, chExp);
		$display("test event %0d done", n);
	endtask : oneEvent

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rst_n    = 1'b0;
		awaddr   = 8'h00;
		araddr   = 8'h00;
		awvalid  = 1'b0;
		wvalid   = 1'b0;
		bready   = 1'b0;
		arvalid  = 1'b0;
		rready   = 1'b0;
		wdata    = 32'h0;
		wstrb    = 4'hf;
		cause    = 12'h000;
		lowPower = 1'b0;
		fails    = 0;
		checked  = 0;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
		// Reset values, read-only place and unmapped place
		busRead(fra_pkg::OFF_MASK, 32'h0, fra_pkg::RESP_OKAY);
		busRead(fra_pkg::OFF_CFG, 32'h0, fra_pkg::RESP_OKAY);
		busRead(fra_pkg::OFF_IRQ_ST, 32'h0, fra_pkg::RESP_OKAY);
		busRead(fra_pkg::OFF_GLOBAL, 32'h0, fra_pkg::RESP_OKAY);
		busWrite(fra_pkg::OFF_PIN, 32'h0, fra_pkg::RESP_OKAY);
		busRead(fra_pkg::OFF_PIN, 32'h1, fra_pkg::RESP_OKAY);
		busWrite(8'h20, 32'h1, fra_pkg::RESP_SLV);
		busRead(8'h20, 32'h0, fra_pkg::RESP_SLV);
		$display("test reset done");
		// Every event kind with its flags and pin decision
		oneEvent(0, 3'h0, 32'h1000, fra_pkg::OFF_CH1, 32'h1, 1'b0);
		oneEvent(3, 3'h0, 32'h2400, fra_pkg::OFF_CH2, 32'h2, 1'b1);
		oneEvent(4, 3'h0, 32'h1400, fra_pkg::OFF_CH1, 32'h4, 1'b1);
		oneEvent(6, 3'h0, 32'h0101, fra_pkg::OFF_CH1, 32'h0, 1'b0);
		oneEvent(7, 3'h0, 32'h0102, fra_pkg::OFF_CH1, 32'h0, 1'b0);
		oneEvent(8, 3'h0, 32'h0110, fra_pkg::OFF_CH1, 32'h0, 1'b0);
		oneEvent(9, 3'h2, 32'h0104, fra_pkg::OFF_CH1, 32'h0, 1'b1);
		oneEvent(10, 3'h0, 32'h0108, fra_pkg::OFF_CH1, 32'h0, 1'b1);
		oneEvent(11, 3'h4, 32'h0108, fra_pkg::OFF_CH1, 32'h0, 1'b1);
		// Masked causes still record but leave the pin alone
		busWrite(fra_pkg::OFF_MASK, 32'h3, fra_pkg::RESP_OKAY);
		busRead(fra_pkg::OFF_MASK, 32'h3, fra_pkg::RESP_OKAY);
		oneEvent(10, 3'h0, 32'h0108, fra_pkg::OFF_CH1, 32'h0, 1'b0);
		oneEvent(9, 3'h2, 32'h0104, fra_pkg::OFF_CH1, 32'h0, 1'b0);
		busWrite(fra_pkg::OFF_MASK, 32'h0, fra_pkg::RESP_OKAY);
		// Short in low power waits for the state to end
		busWrite(fra_pkg::OFF_CFG, 32'h0, fra_pkg::RESP_OKAY);
		lowPower <= 1'b1;
		cause[5] <= 1'b1;
		repeat (8) @(posedge ref_clk);
		check("pinOe lp", {31'h0, pinOe}, 32'h0);
		busRead(fra_pkg::OFF_GLOBAL, 32'h0, fra_pkg::RESP_OKAY);
		lowPower <= 1'b0;
		repeat (8) @(posedge ref_clk);
		check("pinOe active", {31'h0, pinOe}, 32'h1);
		lowPower <= 1'b1;
		repeat (3) @(posedge ref_clk);
		check("pinOe lp", {31'h0, pinOe}, 32'h0);
		lowPower <= 1'b0;
		cause[5] <= 1'b0;
		repeat (8) @(posedge ref_clk);
		clearAll(32'h2400, fra_pkg::OFF_CH2, 32'h4);
		$display("test low power done");
		// Unlatched summary follows the cause; detail bit stays
		busWrite(fra_pkg::OFF_CFG, 32'h1, fra_pkg::RESP_OKAY);
		cause[6] <= 1'b1;
		repeat (8) @(posedge ref_clk);
		check("header", {24'h0, headerByte}, 32'h1);
		cause[6] <= 1'b0;
		repeat (8) @(posedge ref_clk);
		check("header", {24'h0, headerByte}, 32'h0);
		busRead(fra_pkg::OFF_GLOBAL, 32'h1, fra_pkg::RESP_OKAY);
		busRead(fra_pkg::OFF_GLOBAL, 32'h0, fra_pkg::RESP_OKAY);
		$display("test latch disable done");
		// Interrupt raised, read and cleared
		busWrite(fra_pkg::OFF_CFG, 32'h0, fra_pkg::RESP_OKAY);
		busWrite(fra_pkg::OFF_IRQ_MASK, 32'h4, fra_pkg::RESP_OKAY);
		// Every kind of rise has happened above; this read clears them
		busRead(fra_pkg::OFF_IRQ_ST, 32'hf, fra_pkg::RESP_OKAY);
		cause[7] <= 1'b1;
		repeat (8) @(posedge ref_clk);
		check("irq", {31'h0, irq}, 32'h1);
		cause[7] <= 1'b0;
		busRead(fra_pkg::OFF_IRQ_ST, 32'h4, fra_pkg::RESP_OKAY);
		repeat (2) @(posedge ref_clk);
		check("irq", {31'h0, irq}, 32'h0);
		clearAll(32'h0102, fra_pkg::OFF_CH1, 32'h0);
		$display("test interrupt done");
		test_done();
	end

endmodule : test_fra_fault_aggregator
